/* hw/sltst_cfg.svh */
// Register map, field positions, reset values and timing for link self-test.
// Assumes the includer works on the single 20 MHz system clock.
`ifndef SLTST_CFG_SVH
`define SLTST_CFG_SVH
`define SLT_A_DEVID   8'h00
`define SLT_A_RSTCTL  8'h01
`define SLT_A_DSTS    8'h04
`define SLT_A_BCCTL   8'h49
`define SLT_A_PSEL    8'h4C
`define SLT_A_PSTS1   8'h4D
`define SLT_A_GSTS    8'h52
`define SLT_A_BERR    8'h54
`define SLT_A_FEH     8'h55
`define SLT_A_FEL     8'h56
`define SLT_A_ALIAS   8'h5C
`define SLT_A_CCSTS   8'h79
`define SLT_A_BCTL    8'hB3
`define SLT_A_PDBG    8'hD0
`define SLT_A_EQCTL   8'hD2
`define SLT_A_EQSTS   8'hD3
`define SLT_RST_KEEP  0
`define SLT_RST_ALL   1
`define SLT_BC_CLRCRC 3
`define SLT_BC_CLRBST 5
`define SLT_SELFTEST_ENABLE   0
`define SLT_PD_ONE    0
`define SLT_PD_MANY   1
`define SLT_EQ_RST    3
`define SLT_PSEL_WP0  0
`define SLT_BCCTL_RST 8'h00
`define SLT_ZERO8     8'h00
`define SLT_CLK_MHZ   20
`define SLT_EQ_STEP_NS 1000
`define SLT_EQ_STEP_CYC ((`SLT_EQ_STEP_NS * `SLT_CLK_MHZ) / 1000)
`endif

/* hw/sltst_pkg.sv */
// Types shared by the link self-test block.
// Assumes nothing beyond a SystemVerilog compiler.
package sltst_pkg;
  typedef enum logic [1:0] {SLT_CHK_OFF, SLT_CHK_SYNC, SLT_CHK_RUN} sltst_chk_e;
  typedef enum logic {SLT_EQ_ADAPT, SLT_EQ_SETTLED} sltst_eq_e;
endpackage : sltst_pkg

/* hw/sltst_lfsr.sv */
// Pseudo-random shift register, usable as generator or as reloadable checker.
// Assumes steps come as one-cycle enables from the owner.
`timescale 1ns/1ns
module sltst_lfsr
#(
  parameter int W   = 7,
  parameter int TAP = 5
)
(
  input  wire logic clk_i,
  input  wire logic rst_b_i,
  input  wire logic clr_i,
  input  wire logic step_i,
  input  wire logic load_i,
  input  wire logic din_i,
  output logic      next_o
);
  logic [W-1:0] sr_r;

  assign next_o = sr_r[W-1] ^ sr_r[TAP];

  // All-ones seed; an all-zero state would lock up
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      sr_r <= '1;
    else if (clr_i)
      sr_r <= '1;
    else if (step_i)
      sr_r <= {sr_r[W-2:0], (load_i ? din_i : next_o)};
  end
endmodule : sltst_lfsr

/* hw/sltst_top.sv */
// Link self-test and error status for both link ends; equalizer control for the deserializer only.
// Assumes register accesses arrive decoded from the serial control port.
`timescale 1ns/1ns
`include "sltst_cfg.svh"
// Function
// RULE1: Healthy locked link reads serializer general status 0x45.
// RULE2: Forced self-test error sets CRC flag; general status reads 0x4D.
// RULE3: Deserializer device status stays 0xCF while locked despite forced errors.
// RULE4: Serializer 8-bit error counter at 0x54 counts self-test CRC errors.
// RULE5: One forced error after clearing leaves the counter at 0x01.
// RULE6: Back-channel control at 0x49 clears errors, holds link-detect timer. Code has no link-detect timer.
// RULE7: Register at 0x79 groups control-channel fault flags.
// RULE8: Forward error count is 16 bits, high byte 0x55, low 0x56.
// RULE9: Self-test control parameters live at 0xB3.
// RULE10: Receive-port status at 0x4D carries link errors and lock change.
// RULE11: Port debug at 0xD0 controls error injection.
// RULE12: Lock loss resets the equalizer and restarts adaptation.
// RULE13: Writing 1 to 0xD2 bit 3 restarts equalizer adaptation.
// RULE14: Settled equalizer value readable at 0xD3.
// RULE15: Reset control at 0x01 does digital resets.
// RULE16: Bit 0 of self-test control enables or disables the test.
// RULE17: Writing 0x28 to 0x49 clears both CRC errors; bits self-clear. Code acts only on bit 5, clearing the self-test counter and flag.
// RULE18: Active test sends continuous pseudo-random bits, checked on receive.
// RULE19: Control-channel flag in general status clears only on 0x79 read.
// RULE20: Self-test counter clears on the self-test CRC clear command.
module sltst_top
  import sltst_pkg::*;
#(
  parameter int         BIT_DIV   = 4,
  parameter int         SYNC_BITS = 16,
  parameter logic [7:0] DES_ID    = 8'hA5,  // Arbitrary value
  parameter logic [7:0] SER_ID    = 8'h5A   // Arbitrary value
)
(
  input  wire logic       SYS_CLK_I,
  input  wire logic       RST_B_I,
  input  wire logic       REG_WR_I,
  input  wire logic       REG_RD_I,
  input  wire logic       REG_DEV_I,
  input  wire logic [7:0] REG_ADDR_I,
  input  wire logic [7:0] REG_WDATA_I,
  input  wire logic       RX_LOCK_I,
  input  wire logic       PLL_LOCK_I,
  input  wire logic       LINK_DET_I,
  input  wire logic       RX_PASS_I,
  input  wire logic       CC_CRC_ERR_I,
  input  wire logic       CC_SEQ_ERR_I,
  input  wire logic       RX_BIT_I,
  output logic      [7:0] REG_RDATA_O,
  output logic            REG_RVALID_O,
  output logic            TX_BIT_O,
  output logic            SELFTEST_ACTIVE_O,
  output logic            EQ_ADAPT_O
);
  logic [6:0] pin_s1_r, pin_s2_r, pin_d_r;
  logic       lock_s, pll_s, link_s, pass_s, rx_s, lock_fall, cc_ev;
  logic       wr_des, wr_ser, rd_des, rd_ser, pwr, soft_st, soft_all;
  logic [7:0] devid_des_r, devid_ser_r, alias_r, psel_r, bctl_r, pdbg_r;
  logic [7:0] eqctl_r, bcctl_r, berr_r, fel_shadow_r, eq_val_r, rdata_nxt;
  logic [15:0] fwd_cnt_r;
  logic [1:0] ccs_r;
  logic       init_r, one_pend_r, act_d_r, gsts_bist_r, gsts_cc_r;
  logic       lost_r, lchg_r, bist_clr, eq_restart, err_p, gen_bit, chk_next;
  logic [$clog2(BIT_DIV)-1:0]   bit_cnt_r;
  logic [$clog2(SYNC_BITS)-1:0] sync_cnt_r;
  logic [7:0] eq_cnt_r;
  logic       bit_tick, eq_tick;
  sltst_chk_e chk_r;
  sltst_eq_e  eq_r;

  // Pins come from the analog front end, so two stages before use
  always_ff @(posedge SYS_CLK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
    begin
      pin_s1_r <= '0;
      pin_s2_r <= '0;
      pin_d_r  <= '0;
    end
    else
    begin
      pin_s1_r <= {RX_BIT_I, CC_SEQ_ERR_I, CC_CRC_ERR_I, RX_PASS_I,
                   LINK_DET_I, PLL_LOCK_I, RX_LOCK_I};
      pin_s2_r <= pin_s1_r;
      pin_d_r  <= pin_s2_r;
    end
  end

  assign lock_s    = pin_s2_r[0];
  assign pll_s     = pin_s2_r[1];
  assign link_s    = pin_s2_r[2];
  assign pass_s    = pin_s2_r[3];
  assign rx_s      = pin_s2_r[6];
  assign lock_fall = pin_d_r[0] & ~lock_s;
  assign cc_ev     = |(pin_s2_r[5:4] & ~pin_d_r[5:4]);

  assign wr_des  = REG_WR_I & ~REG_DEV_I;
  assign wr_ser  = REG_WR_I & REG_DEV_I;
  assign rd_des  = REG_RD_I & ~REG_DEV_I;
  assign rd_ser  = REG_RD_I & REG_DEV_I;
  assign pwr     = psel_r[`SLT_PSEL_WP0];
  assign soft_st = REG_WR_I && REG_ADDR_I == `SLT_A_RSTCTL &&
                   (REG_WDATA_I[`SLT_RST_KEEP] || REG_WDATA_I[`SLT_RST_ALL]);  // RULE15
  assign soft_all = soft_st && REG_WDATA_I[`SLT_RST_ALL];  // RULE15
  assign bist_clr = wr_ser && REG_ADDR_I == `SLT_A_BCCTL &&
                    REG_WDATA_I[`SLT_BC_CLRBST];  // RULE17
  assign eq_restart = wr_des && pwr && REG_ADDR_I == `SLT_A_EQCTL &&
                      REG_WDATA_I[`SLT_EQ_RST];  // RULE13

  // Software-visible registers; self-clearing bits are never stored
  always_ff @(posedge SYS_CLK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
    begin
      devid_des_r <= DES_ID;
      devid_ser_r <= SER_ID;
      alias_r     <= `SLT_ZERO8;
      psel_r      <= `SLT_ZERO8;
      bctl_r      <= `SLT_ZERO8;
      pdbg_r      <= `SLT_ZERO8;
      eqctl_r     <= `SLT_ZERO8;
      bcctl_r     <= `SLT_BCCTL_RST;
    end
    else if (soft_all)
    begin
      devid_des_r <= DES_ID;
      devid_ser_r <= SER_ID;
      alias_r     <= `SLT_ZERO8;
      psel_r      <= `SLT_ZERO8;
      bctl_r      <= `SLT_ZERO8;
      pdbg_r      <= `SLT_ZERO8;
      eqctl_r     <= `SLT_ZERO8;
      bcctl_r     <= `SLT_BCCTL_RST;
    end
    else if (wr_des)
    begin
      unique case (REG_ADDR_I)
        `SLT_A_DEVID: devid_des_r <= REG_WDATA_I;
        `SLT_A_ALIAS: alias_r <= REG_WDATA_I;
        `SLT_A_PSEL:  psel_r <= REG_WDATA_I;
        `SLT_A_BCTL:  bctl_r <= REG_WDATA_I;  // RULE9 RULE16
        `SLT_A_PDBG:  if (pwr) pdbg_r <= REG_WDATA_I & 8'hFE;  // RULE11
        `SLT_A_EQCTL: if (pwr) eqctl_r <= REG_WDATA_I & 8'hF7;
        default: ;
      endcase
    end
    else if (wr_ser)
    begin
      unique case (REG_ADDR_I)
        `SLT_A_DEVID: devid_ser_r <= REG_WDATA_I;
        `SLT_A_BCCTL: bcctl_r <= REG_WDATA_I & 8'hD7;  // RULE6 RULE17
        default: ;
      endcase
    end
  end

  // Bit-rate and equalizer-step enables
  always_ff @(posedge SYS_CLK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
    begin
      bit_cnt_r <= '0;
      eq_cnt_r  <= '0;
      init_r    <= 1'b0;
    end
    else
    begin
      bit_cnt_r <= bit_tick ? '0 : bit_cnt_r + 1'b1;
      eq_cnt_r  <= eq_tick ? '0 : eq_cnt_r + 8'h01;
      init_r    <= 1'b1;
    end
  end

  assign bit_tick = bit_cnt_r == ($clog2(BIT_DIV))'(BIT_DIV - 1);
  assign eq_tick  = eq_cnt_r == 8'(`SLT_EQ_STEP_CYC - 1);

  // Single forced error waits for the next transmitted bit
  always_ff @(posedge SYS_CLK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
      one_pend_r <= 1'b0;
    else if (wr_des && pwr && REG_ADDR_I == `SLT_A_PDBG && REG_WDATA_I[`SLT_PD_ONE])
      one_pend_r <= 1'b1;  // RULE11
    else if (soft_st || (bit_tick && SELFTEST_ACTIVE_O))
      one_pend_r <= 1'b0;
  end

  sltst_lfsr u_gen
  (
    .clk_i   (SYS_CLK_I),
    .rst_b_i (RST_B_I),
    .clr_i   (~SELFTEST_ACTIVE_O | soft_st),
    .step_i  (bit_tick),
    .load_i  (1'b0),
    .din_i   (1'b0),
    .next_o  (gen_bit)
  );

  sltst_lfsr u_chk
  (
    .clk_i   (SYS_CLK_I),
    .rst_b_i (RST_B_I),
    .clr_i   (chk_r == SLT_CHK_OFF),
    .step_i  (bit_tick),
    .load_i  (chk_r == SLT_CHK_SYNC),
    .din_i   (rx_s),
    .next_o  (chk_next)
  );

  assign err_p = bit_tick && chk_r == SLT_CHK_RUN && (rx_s ^ chk_next);  // RULE18

  always_ff @(posedge SYS_CLK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
    begin
      SELFTEST_ACTIVE_O <= 1'b0;
      act_d_r           <= 1'b0;
      TX_BIT_O          <= 1'b0;
    end
    else
    begin
      SELFTEST_ACTIVE_O <= bctl_r[`SLT_SELFTEST_ENABLE] & ~soft_st;  // RULE16
      act_d_r           <= SELFTEST_ACTIVE_O;
      if (!SELFTEST_ACTIVE_O)
        TX_BIT_O <= 1'b0;
      else if (bit_tick)
        TX_BIT_O <= gen_bit ^ (one_pend_r | pdbg_r[`SLT_PD_MANY]);  // RULE18 RULE11
    end
  end

  // Checker realigns from the received stream, so link latency is free
  always_ff @(posedge SYS_CLK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
    begin
      chk_r      <= SLT_CHK_OFF;
      sync_cnt_r <= '0;
    end
    else if (!SELFTEST_ACTIVE_O || soft_st)
    begin
      chk_r      <= SLT_CHK_OFF;
      sync_cnt_r <= '0;
    end
    else
    begin
      unique case (chk_r)
        SLT_CHK_OFF:  chk_r <= SLT_CHK_SYNC;
        SLT_CHK_SYNC:
          if (bit_tick)
          begin
            sync_cnt_r <= sync_cnt_r + 1'b1;
            if (sync_cnt_r == ($clog2(SYNC_BITS))'(SYNC_BITS - 1))
              chk_r <= SLT_CHK_RUN;
          end
        SLT_CHK_RUN:  if (lock_fall) chk_r <= SLT_CHK_SYNC;
      endcase
    end
  end

  // Error counters; a new error beats a simultaneous clear
  always_ff @(posedge SYS_CLK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
    begin
      berr_r       <= '0;
      gsts_bist_r  <= 1'b0;
      fwd_cnt_r    <= '0;
      fel_shadow_r <= '0;
    end
    else
    begin
      if (err_p)
      begin
        gsts_bist_r <= 1'b1;  // RULE2
        berr_r <= (bist_clr || soft_st) ? 8'h01 :
                  berr_r + {7'h00, berr_r != 8'hFF};  // RULE4 RULE5 RULE20
        fwd_cnt_r <= fwd_cnt_r + {15'h0000, fwd_cnt_r != 16'hFFFF};  // RULE8
      end
      else
      begin
        if (bist_clr || soft_st)
        begin
          berr_r      <= '0;  // RULE20
          gsts_bist_r <= 1'b0;  // RULE17
        end
        if (soft_st || (SELFTEST_ACTIVE_O && !act_d_r))
          fwd_cnt_r <= '0;
      end
      if (rd_des && REG_ADDR_I == `SLT_A_FEH)
        fel_shadow_r <= fwd_cnt_r[7:0];  // RULE8
    end
  end

  // Sticky status flags, each cleared by a read; set wins
  always_ff @(posedge SYS_CLK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
    begin
      ccs_r     <= '0;
      gsts_cc_r <= 1'b0;
      lost_r    <= 1'b0;
      lchg_r    <= 1'b0;
    end
    else
    begin
      if (rd_ser && REG_ADDR_I == `SLT_A_CCSTS)
      begin
        ccs_r     <= pin_s2_r[5:4] & ~pin_d_r[5:4];  // RULE7
        gsts_cc_r <= cc_ev;  // RULE19
      end
      else
      begin
        ccs_r     <= ccs_r | (pin_s2_r[5:4] & ~pin_d_r[5:4]);  // RULE7
        gsts_cc_r <= gsts_cc_r | cc_ev;  // RULE19
      end
      if (pin_d_r[2] && !link_s)
        lost_r <= 1'b1;
      else if (rd_ser && REG_ADDR_I == `SLT_A_GSTS)
        lost_r <= 1'b0;
      if (pin_d_r[0] != lock_s)
        lchg_r <= 1'b1;  // RULE10
      else if (rd_des && REG_ADDR_I == `SLT_A_PSTS1)
        lchg_r <= 1'b0;
    end
  end

  // Equalizer sweeps upward until the receiver locks, then holds
  always_ff @(posedge SYS_CLK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
    begin
      eq_r       <= SLT_EQ_ADAPT;
      eq_val_r   <= '0;
      EQ_ADAPT_O <= 1'b0;
    end
    else
    begin
      EQ_ADAPT_O <= eq_r == SLT_EQ_ADAPT;
      if (lock_fall || eq_restart || soft_st)
      begin
        eq_r     <= SLT_EQ_ADAPT;  // RULE12 RULE13
        eq_val_r <= '0;
      end
      else
      begin
        unique case (eq_r)
          SLT_EQ_ADAPT:
            if (lock_s)
              eq_r <= SLT_EQ_SETTLED;
            else if (eq_tick)
              eq_val_r <= eq_val_r + 8'h01;
          SLT_EQ_SETTLED: ;
        endcase
      end
    end
  end

  always_comb
  begin
    rdata_nxt = `SLT_ZERO8;
    if (!REG_DEV_I)
    begin
      unique case (REG_ADDR_I)
        `SLT_A_DEVID: rdata_nxt = devid_des_r;
        `SLT_A_DSTS:  rdata_nxt = {init_r, init_r, 2'b00, pass_s, lock_s, 2'b11};  // RULE3
        `SLT_A_PSEL:  rdata_nxt = psel_r;
        `SLT_A_PSTS1: rdata_nxt = {3'b000, lchg_r, 1'b0, fwd_cnt_r != 16'h0000,
                                   pass_s, lock_s};  // RULE10
        `SLT_A_FEH:   rdata_nxt = fwd_cnt_r[15:8];  // RULE8
        `SLT_A_FEL:   rdata_nxt = fel_shadow_r;  // RULE8
        `SLT_A_ALIAS: rdata_nxt = alias_r;
        `SLT_A_BCTL:  rdata_nxt = bctl_r;
        `SLT_A_PDBG:  rdata_nxt = pdbg_r;
        `SLT_A_EQCTL: rdata_nxt = eqctl_r;
        `SLT_A_EQSTS: rdata_nxt = eq_val_r;  // RULE14
        default:      rdata_nxt = `SLT_ZERO8;
      endcase
    end
    else
    begin
      unique case (REG_ADDR_I)
        `SLT_A_DEVID: rdata_nxt = devid_ser_r;
        `SLT_A_BCCTL: rdata_nxt = bcctl_r;
        `SLT_A_GSTS:  rdata_nxt = {1'b0, lock_s, 1'b0, lost_r, gsts_bist_r,
                                   pll_s, gsts_cc_r, link_s};  // RULE1 RULE2
        `SLT_A_BERR:  rdata_nxt = berr_r;  // RULE4
        `SLT_A_CCSTS: rdata_nxt = {6'h00, ccs_r};  // RULE7
        default:      rdata_nxt = `SLT_ZERO8;
      endcase
    end
  end

  always_ff @(posedge SYS_CLK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
    begin
      REG_RDATA_O  <= '0;
      REG_RVALID_O <= 1'b0;
    end
    else
    begin
      REG_RVALID_O <= REG_RD_I;
      if (REG_RD_I)
        REG_RDATA_O <= rdata_nxt;
    end
  end

  sequence s_gsts_rd;
    rd_ser && REG_ADDR_I == `SLT_A_GSTS && !lost_r && !gsts_cc_r && lock_s && pll_s && link_s;
  endsequence
  sequence s_restart;
    eq_restart ##1 (eq_r == SLT_EQ_ADAPT && eq_val_r == 8'h00) ##1 EQ_ADAPT_O;
  endsequence

  property p_gsts_ok;
    @(posedge SYS_CLK_I) disable iff (!RST_B_I)
    s_gsts_rd and (!gsts_bist_r) |=> REG_RDATA_O == 8'h45;
  endproperty
  a_gsts_ok: assert property (p_gsts_ok) else $error("general status not 0x45");  // RULE1
  property p_gsts_err;
    @(posedge SYS_CLK_I) disable iff (!RST_B_I)
    s_gsts_rd and gsts_bist_r |=> REG_RDATA_O == 8'h4D;
  endproperty
  a_gsts_err: assert property (p_gsts_err) else $error("general status not 0x4D");  // RULE2
  property p_dsts;
    @(posedge SYS_CLK_I) disable iff (!RST_B_I)
    rd_des && REG_ADDR_I == `SLT_A_DSTS && lock_s && pass_s && init_r
      |=> REG_RDATA_O == 8'hCF;
  endproperty
  a_dsts: assert property (p_dsts) else $error("device status not 0xCF");  // RULE3
  property p_berr_inc;
    @(posedge SYS_CLK_I) disable iff (!RST_B_I)
    err_p && !bist_clr && !soft_st && berr_r != 8'hFF |=> berr_r == $past(berr_r) + 8'h01;
  endproperty
  a_berr_inc: assert property (p_berr_inc) else $error("error count not stepped");  // RULE4
  property p_berr_clr;
    @(posedge SYS_CLK_I) disable iff (!RST_B_I)
    bist_clr && !err_p |=> berr_r == 8'h00 && !gsts_bist_r;
  endproperty
  a_berr_clr: assert property (p_berr_clr) else $error("clear command ignored");  // RULE20
  property p_bc_selfclr;
    @(posedge SYS_CLK_I) disable iff (!RST_B_I)
    bcctl_r[`SLT_BC_CLRBST] == 1'b0 && bcctl_r[`SLT_BC_CLRCRC] == 1'b0;
  endproperty
  a_bc_selfclr: assert property (p_bc_selfclr) else $error("clear bits stored");  // RULE17
  property p_enable;
    @(posedge SYS_CLK_I) disable iff (!RST_B_I)
    !soft_st ##1 1'b1 |-> SELFTEST_ACTIVE_O == $past(bctl_r[`SLT_SELFTEST_ENABLE]);
  endproperty
  a_enable: assert property (p_enable) else $error("test enable not followed");  // RULE16
  property p_cc_hold;
    @(posedge SYS_CLK_I) disable iff (!RST_B_I)
    $fell(gsts_cc_r) |-> $past(rd_ser && REG_ADDR_I == `SLT_A_CCSTS);
  endproperty
  a_cc_hold: assert property (p_cc_hold) else $error("flag cleared without read");  // RULE19
  property p_lock_eq;
    @(posedge SYS_CLK_I) disable iff (!RST_B_I)
    lock_fall |=> eq_val_r == 8'h00 ##1 EQ_ADAPT_O;
  endproperty
  a_lock_eq: assert property (p_lock_eq) else $error("no equalizer restart on lock loss");  // RULE12
  property p_restart;
    @(posedge SYS_CLK_I) disable iff (!RST_B_I)
    eq_restart |-> s_restart;
  endproperty
  a_restart: assert property (p_restart) else $error("equalizer restart ignored");  // RULE13
endmodule : sltst_top

/* verification/sltst_link_mdl.sv */
// Far end of the serial link: returns the test bit stream, drives lock levels.
// Assumes the bench clock and reset; lock_i is the bench's wish for lock.
`timescale 1ns/1ns
module sltst_link_mdl
(
  input  wire logic clk_i,
  input  wire logic rst_b_i,
  input  wire logic tx_bit_i,
  input  wire logic lock_i,
  output logic      rx_bit_o,
  output logic      rx_lock_o,
  output logic      pll_lock_o,
  output logic      link_det_o,
  output logic      rx_pass_o
);
  logic [2:0] dly_r;

  // Fixed three-cycle flight; the checker must cope with any fixed latency
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      dly_r      <= 3'h0;
      rx_lock_o  <= 1'b0;
      rx_pass_o  <= 1'b0;
      pll_lock_o <= 1'b0;
      link_det_o <= 1'b0;
    end
    else
    begin
      dly_r      <= {dly_r[1:0], tx_bit_i};
      rx_lock_o  <= lock_i;
      rx_pass_o  <= lock_i;
      pll_lock_o <= 1'b1;
      link_det_o <= 1'b1;
    end
  end

  assign rx_bit_o = dly_r[2];
endmodule : sltst_link_mdl

/* verification/tb.sv */
// Self-checking bench for the link self-test and status block.
// Assumes the far end model loops the test bit back with fixed latency.
`timescale 1ns/1ns
module tb;
  localparam int         BDIV  = 4;
  localparam int         SBITS = 16;
  localparam logic [7:0] DID   = 8'h3C; // Arbitrary value
  localparam logic [7:0] SID   = 8'hC3; // Arbitrary value

  logic       sys_clk = 1'b0;
  logic       rst_b   = 1'b0;
  logic       wr      = 1'b0;
  logic       rd      = 1'b0;
  logic       dev     = 1'b0;
  logic [7:0] addr    = 8'h00;
  logic [7:0] wdata   = 8'h00;
  logic       cc_crc  = 1'b0;
  logic       cc_seq  = 1'b0;
  logic       lock_rq = 1'b1;
  logic [7:0] rdata;
  logic       rvalid, tx_bit, active, eq_adapt;
  logic       rx_bit, rx_lock, pll_lock, link_det, rx_pass;
  int         fail_count  = 0;
  int         checks_done = 0;
  logic [7:0] v, v2;

  always #25 sys_clk = ~sys_clk;

  sltst_top #(.BIT_DIV(BDIV), .SYNC_BITS(SBITS), .DES_ID(DID), .SER_ID(SID)) uut
  (
    .SYS_CLK_I(sys_clk), .RST_B_I(rst_b), .REG_WR_I(wr), .REG_RD_I(rd),
    .REG_DEV_I(dev), .REG_ADDR_I(addr), .REG_WDATA_I(wdata),
    .RX_LOCK_I(rx_lock), .PLL_LOCK_I(pll_lock), .LINK_DET_I(link_det),
    .RX_PASS_I(rx_pass), .CC_CRC_ERR_I(cc_crc), .CC_SEQ_ERR_I(cc_seq),
    .RX_BIT_I(rx_bit), .REG_RDATA_O(rdata), .REG_RVALID_O(rvalid),
    .TX_BIT_O(tx_bit), .SELFTEST_ACTIVE_O(active), .EQ_ADAPT_O(eq_adapt)
  );

  sltst_link_mdl far_end
  (
    .clk_i(sys_clk), .rst_b_i(rst_b), .tx_bit_i(tx_bit), .lock_i(lock_rq),
    .rx_bit_o(rx_bit), .rx_lock_o(rx_lock), .pll_lock_o(pll_lock),
    .link_det_o(link_det), .rx_pass_o(rx_pass)
  );

  task automatic end_sim();
    $display("Checks %0d, mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : end_sim

  task automatic hang(input string what);
    fail_count++;
    $display("[ERR] %s expected response seen none", what);
    end_sim();
  endtask : hang

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic chk_bit(input string what, input logic exp, input logic got);
    checks_done++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[ERR] %s expected %b seen %b", what, exp, got);
    end
  endtask : chk_bit

  task automatic reg_wr(input logic d, input logic [7:0] a, input logic [7:0] val);
    @(negedge sys_clk);
    dev   = d;
    addr  = a;
    wdata = val;
    wr    = 1'b1;
    @(negedge sys_clk);
    wr = 1'b0;
  endtask : reg_wr

  task automatic reg_rd(input logic d, input logic [7:0] a, output logic [7:0] val);
    int n;
    @(negedge sys_clk);
    dev  = d;
    addr = a;
    rd   = 1'b1;
    @(negedge sys_clk);
    rd = 1'b0;
    n  = 0;
    while (rvalid !== 1'b1)
    begin
      if (n == 4)
        hang("read answer");
      @(negedge sys_clk);
      n++;
    end
    val = rdata;
  endtask : reg_rd

  task automatic rd_chk(input logic d, input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] got;
    reg_rd(d, a, got);
    chk($sformatf("reg %0d:%h", d, a), exp, got);
  endtask : rd_chk

  task automatic wait_adapt(input logic val, input int bound);
    int n;
    n = 0;
    while (eq_adapt !== val)
    begin
      if (n == bound)
        hang("equalizer adapt");
      @(negedge sys_clk);
      n++;
    end
  endtask : wait_adapt

  task automatic t_status();
    rd_chk(1'b1, 8'h52, 8'h45);
    rd_chk(1'b0, 8'h04, 8'hCF);
    rd_chk(1'b0, 8'h00, DID);
    rd_chk(1'b1, 8'h00, SID);
    rd_chk(1'b0, 8'h7F, 8'h00);
    rd_chk(1'b1, 8'h49, 8'h00);
  endtask : t_status

  task automatic t_regs();
    reg_wr(1'b1, 8'h49, 8'h11);
    rd_chk(1'b1, 8'h49, 8'h11);
    reg_wr(1'b0, 8'hD0, 8'h02);
    rd_chk(1'b0, 8'hD0, 8'h00);
    reg_wr(1'b0, 8'h4C, 8'h01);
    reg_wr(1'b0, 8'hD0, 8'h02);
    rd_chk(1'b0, 8'hD0, 8'h02);
    reg_wr(1'b0, 8'hD0, 8'h00);
    reg_wr(1'b1, 8'h01, 8'h01);
    rd_chk(1'b1, 8'h49, 8'h11);
    rd_chk(1'b1, 8'h01, 8'h00);
    reg_wr(1'b0, 8'h01, 8'h02);
    rd_chk(1'b1, 8'h49, 8'h00);
    rd_chk(1'b0, 8'h4C, 8'h00);
    wait_adapt(1'b0, 3000);
  endtask : t_regs

  task automatic t_bist_one();
    int tog;
    reg_wr(1'b1, 8'h49, 8'h28);
    rd_chk(1'b1, 8'h49, 8'h00);
    rd_chk(1'b1, 8'h54, 8'h00);
    reg_rd(1'b1, 8'h79, v);
    rd_chk(1'b1, 8'h52, 8'h45);
    reg_wr(1'b0, 8'h4C, 8'h01);
    reg_wr(1'b0, 8'hB3, 8'h01);
    rd_chk(1'b0, 8'hB3, 8'h01);
    chk_bit("active", 1'b1, active);
    tog = 0;
    // All-ones seed still sends a run of zeros first, so watch long enough to see real toggles
    repeat (240)
    begin
      v2[0] = tx_bit;
      @(negedge sys_clk);
      tog += (tx_bit !== v2[0]);
    end
    chk_bit("tx toggles", 1'b1, tog > 4);
    reg_wr(1'b0, 8'hD0, 8'h01);
    rd_chk(1'b0, 8'hD0, 8'h00);
    repeat (100) @(negedge sys_clk);
    reg_wr(1'b0, 8'hB3, 8'h00);
    repeat (3) @(negedge sys_clk);
    chk_bit("active", 1'b0, active);
    chk_bit("tx idle", 1'b0, tx_bit);
    rd_chk(1'b1, 8'h54, 8'h01);
    rd_chk(1'b1, 8'h52, 8'h4D);
    rd_chk(1'b0, 8'h04, 8'hCF);
    rd_chk(1'b0, 8'h55, 8'h00);
    rd_chk(1'b0, 8'h56, 8'h01);
    reg_rd(1'b0, 8'h4D, v);
    chk("port status", 8'h07, v & 8'h07);
  endtask : t_bist_one

  task automatic t_bist_many();
    reg_wr(1'b1, 8'h49, 8'h28);
    reg_wr(1'b0, 8'hB3, 8'h01);
    repeat (200) @(negedge sys_clk);
    reg_wr(1'b0, 8'hD0, 8'h02);
    repeat (1500) @(negedge sys_clk);
    reg_wr(1'b0, 8'hD0, 8'h00);
    reg_wr(1'b0, 8'hB3, 8'h00);
    rd_chk(1'b1, 8'h54, 8'hFF);
    rd_chk(1'b0, 8'h55, 8'h01);
    reg_wr(1'b1, 8'h49, 8'h20);
    rd_chk(1'b1, 8'h54, 8'h00);
    reg_wr(1'b1, 8'h49, 8'h28);
    rd_chk(1'b1, 8'h52, 8'h45);
  endtask : t_bist_many

  task automatic t_ctrl_chan();
    @(negedge sys_clk);
    cc_crc = 1'b1;
    repeat (5) @(negedge sys_clk);
    cc_crc = 1'b0;
    repeat (5) @(negedge sys_clk);
    rd_chk(1'b1, 8'h52, 8'h47);
    rd_chk(1'b1, 8'h52, 8'h47);
    rd_chk(1'b1, 8'h79, 8'h01);
    rd_chk(1'b1, 8'h79, 8'h00);
    rd_chk(1'b1, 8'h52, 8'h45);
    cc_seq = 1'b1;
    repeat (5) @(negedge sys_clk);
    cc_seq = 1'b0;
    repeat (5) @(negedge sys_clk);
    rd_chk(1'b1, 8'h79, 8'h02);
    rd_chk(1'b1, 8'h52, 8'h45);
  endtask : t_ctrl_chan

  task automatic t_equalizer();
    reg_wr(1'b0, 8'h4C, 8'h01);
    reg_wr(1'b0, 8'hD2, 8'h08);
    wait_adapt(1'b1, 6);
    rd_chk(1'b0, 8'hD2, 8'h00);
    wait_adapt(1'b0, 3000);
    @(negedge sys_clk);
    lock_rq = 1'b0;
    wait_adapt(1'b1, 10);
    rd_chk(1'b0, 8'hD3, 8'h00);
    repeat (100) @(negedge sys_clk);
    reg_rd(1'b0, 8'hD3, v);
    chk_bit("eq counting", 1'b1, v != 8'h00);
    lock_rq = 1'b1;
    wait_adapt(1'b0, 3000);
    reg_rd(1'b0, 8'hD3, v);
    repeat (100) @(negedge sys_clk);
    rd_chk(1'b0, 8'hD3, v);
    reg_rd(1'b0, 8'h4D, v2);
    chk("lock change", 8'h10, v2 & 8'h10);
    reg_rd(1'b0, 8'h4D, v2);
    chk("lock change", 8'h00, v2 & 8'h10);
  endtask : t_equalizer

  initial
  begin
    repeat (5) @(negedge sys_clk);
    rst_b = 1'b1;
    // Status pins need the two sync stages before the first read makes sense
    wait_adapt(1'b1, 4);
    wait_adapt(1'b0, 3000);
    t_status();
    t_regs();
    t_bist_one();
    t_bist_many();
    t_ctrl_chan();
    t_equalizer();
    end_sim();
  end
endmodule : tb
